/* hdl/twpdc_pkg.sv */
package twpdc_pkg;
    // Serial framing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic [6:0] DEV_ADDR = 7'h65;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [2:0] DUMMY_BYTES = 3'h2;
    localparam logic [2:0] CFG_BYTES = 3'h3;
    localparam logic [2:0] WR_BYTE_LIMIT = 3'h5;
    localparam logic [7:0] DUMMY_VALUE = 8'h00;
    // Field layout of the configuration bytes
    localparam int BYPASS_BIT = 7;
    localparam int SELECT_BIT = 6;
    localparam int REF_CODE_W = 6;
    localparam int FB_CODE_W = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Divider arithmetic
    localparam int FB_EFF_W = 10;
    localparam int REF_EFF_W = 7;
    localparam logic [FB_EFF_W-1:0] FB_OFFSET = 10'h003;
    localparam int FB_SHIFT = 1;
    localparam logic [REF_EFF_W-1:0] REF_OFFSET = 7'h02;
    localparam logic [REF_EFF_W-1:0] REF_BYPASS_DIV = 7'h01;
    localparam logic [FB_EFF_W-1:0] PIN_MULT_LOW = 10'h010;
    localparam logic [FB_EFF_W-1:0] PIN_MULT_HIGH = 10'h008;
    // Host serial clock timing
    localparam int CORE_CLK_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CORE_CLK_NS);
    localparam int QTR_W = 12;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_ADDR_ST = 3'b001,
        DEV_ACK = 3'b010,
        DEV_WDATA = 3'b011,
        DEV_RDATA = 3'b100,
        DEV_RACK = 3'b101,
        DEV_IGNORE = 3'b110
    } twpdc_dev_state_type;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_START = 2'b01,
        HST_BIT = 2'b10,
        HST_STOP = 2'b11
    } twpdc_host_state_type;
endpackage

/* hdl/twpdc_if.sv */
interface twpdc_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic serial_clock_pin;
    logic serial_data_pin;

    // Open-drain wires with pull-up
    assign serial_clock_pin = ~(host_scl_oe & ~host_scl_out);
    assign serial_data_pin = ~(host_sda_oe & ~host_sda_out) & ~(dev_sda_oe & ~dev_sda_out);

    modport device (
        input serial_clock_pin,
        input serial_data_pin,
        output dev_sda_out,
        output dev_sda_oe
    );

    modport host (
        input serial_clock_pin,
        input serial_data_pin,
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe
    );
endinterface

/* hdl/twpdc_sync.sv */
module twpdc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic clk_en, // Clock enable
    input wire logic [WIDTH-1:0] async_in, // Pins from outside
    output logic [WIDTH-1:0] sync_out // Second stage
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            stage_r <= '0;
        end else if (clk_en) begin
            meta_r <= async_in;
            stage_r <= meta_r;
        end
    end

    assign sync_out = stage_r;
endmodule

/* hdl/twpdc_device.sv */
// Summary of operation
// - Master opens each transfer with start
// - Master closes each transfer with stop
// - Data changes only while clock low
// - Acknowledger holds data low through clock high
// - First byte is address plus direction
// - Device acknowledges its own address, MSB first
// - Direction zero writes, one reads
// - Every segment is eight bits plus acknowledge
// - Receiver acknowledges each transferred byte, except the master leaves the last read byte unacknowledged
// - Two dummy bytes precede write data; reads begin with the first config byte
// - Latch three bytes, third reserved, ignore extras
// - First byte: bypass, select, reference code
// - Select defaults low, high enables serial codes
// - Feedback (code+3)*2, reference code+2
// - Bypass bit forces reference divider to one
// - Select low uses the multiplier pin
// - Pin low gives x16, high x8
// - Source select high routes bypass input
// - Output equals reference times feedback over reference
// - Only master drives clock, device drives data
module twpdc_device (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic clk_en, // Freezes all state when low
    twpdc_if.device bus, // Serial link
    input wire logic pll_mult_sel, // Multiplier select pin
    input wire logic clk_source_sel, // Clock source select pin
    output logic ref_divider_bypass, // Latched bypass bit
    output logic use_programmed_dividers, // Latched select bit
    output logic [twpdc_pkg::REF_CODE_W-1:0] ref_div_code, // Latched reference code
    output logic [twpdc_pkg::FB_CODE_W-1:0] fb_div_code, // Latched feedback code
    output logic [twpdc_pkg::FB_EFF_W-1:0] feedback_divider, // Effective feedback divider
    output logic [twpdc_pkg::REF_EFF_W-1:0] reference_divider, // Effective reference divider
    output logic bypass_clock_select // High routes bypass_diff_clock_in
);
    import twpdc_pkg::*;

    function automatic logic [FB_EFF_W-1:0] fb_final(input logic [FB_CODE_W-1:0] code);
        logic [FB_EFF_W-1:0] sum;
        sum = FB_EFF_W'(code) + FB_OFFSET;
        return sum << FB_SHIFT;
    endfunction

    function automatic logic [REF_EFF_W-1:0] ref_final(input logic [7:0] ctrl);
        logic [REF_EFF_W-1:0] div;
        div = REF_EFF_W'(ctrl[REF_CODE_W-1:0]) + REF_OFFSET;
        if (ctrl[BYPASS_BIT]) begin
            div = REF_BYPASS_DIV;
        end
        return div;
    endfunction

    function automatic logic [7:0] cfg_pick(
        input logic [2:0] idx,
        input logic [7:0] b0,
        input logic [7:0] b1,
        input logic [7:0] b2
    );
        logic [7:0] val;
        case (idx)
            3'h0: val = b0;
            3'h1: val = b1;
            3'h2: val = b2;
            default: val = CFG_RESET;
        endcase
        return val;
    endfunction

    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic mult_s;
    logic src_s;

    twpdc_sync #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({bus.serial_clock_pin, bus.serial_data_pin, pll_mult_sel, clk_source_sel}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign mult_s = pins_s[1];
    assign src_s = pins_s[0];

    twpdc_dev_state_type state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [2:0] byte_cnt_r, byte_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic rw_r, rw_nxt;
    logic mack_r, mack_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic scl_d_r, scl_d_nxt;
    logic sda_d_r, sda_d_nxt;
    logic [7:0] cfg0_r, cfg0_nxt;
    logic [7:0] cfg1_r, cfg1_nxt;
    logic [7:0] cfg2_r, cfg2_nxt;
    logic [FB_EFF_W-1:0] fb_eff_r, fb_eff_nxt;
    logic [REF_EFF_W-1:0] ref_eff_r, ref_eff_nxt;
    logic src_sel_r, src_sel_nxt;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_byte;

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        byte_cnt_nxt = byte_cnt_r;
        shift_nxt = shift_r;
        rw_nxt = rw_r;
        mack_nxt = mack_r;
        sda_oe_nxt = sda_oe_r;
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        scl_d_nxt = scl_s;
        sda_d_nxt = sda_s;
        rd_byte = CFG_RESET;
        scl_rise = scl_s & ~scl_d_r;
        scl_fall = ~scl_s & scl_d_r;
        start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
        stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s;
        if (stop_seen) begin
            state_nxt = DEV_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (start_seen) begin
            state_nxt = DEV_ADDR_ST;
            bit_cnt_nxt = '0;
            byte_cnt_nxt = '0;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                DEV_ADDR_ST, DEV_WDATA: begin
                    if (scl_rise && bit_cnt_r != BIT_CNT_FULL) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == BIT_CNT_FULL) begin
                        bit_cnt_nxt = '0;
                        if (state_r == DEV_ADDR_ST) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_nxt = shift_r[0];
                                sda_oe_nxt = 1'b1;
                                state_nxt = DEV_ACK;
                            end else begin
                                state_nxt = DEV_IGNORE;
                            end
                        end else begin
                            case (byte_cnt_r)
                                DUMMY_BYTES: cfg0_nxt = shift_r;
                                DUMMY_BYTES + 3'h1: cfg1_nxt = shift_r;
                                DUMMY_BYTES + 3'h2: cfg2_nxt = shift_r;
                                default: ;
                            endcase
                            if (byte_cnt_r != WR_BYTE_LIMIT) begin
                                byte_cnt_nxt = byte_cnt_r + 3'h1;
                            end
                            sda_oe_nxt = 1'b1;
                            state_nxt = DEV_ACK;
                        end
                    end
                end
                DEV_ACK: begin
                    if (scl_fall) begin
                        sda_oe_nxt = 1'b0;
                        bit_cnt_nxt = '0;
                        if (rw_r == RW_READ) begin
                            rd_byte = cfg_pick(byte_cnt_r, cfg0_r, cfg1_r, cfg2_r);
                            shift_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            state_nxt = DEV_RDATA;
                        end else begin
                            state_nxt = DEV_WDATA;
                        end
                    end
                end
                DEV_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == BIT_CNT_FULL) begin
                            sda_oe_nxt = 1'b0;
                            bit_cnt_nxt = '0;
                            state_nxt = DEV_RACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sda_oe_nxt = ~shift_r[6];
                        end
                    end
                end
                DEV_RACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            if (byte_cnt_r != CFG_BYTES) begin
                                byte_cnt_nxt = byte_cnt_r + 3'h1;
                            end
                            rd_byte = cfg_pick(byte_cnt_r + 3'h1, cfg0_r, cfg1_r, cfg2_r);
                            shift_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            state_nxt = DEV_RDATA;
                        end else begin
                            state_nxt = DEV_IGNORE;
                        end
                    end
                end
                DEV_IDLE, DEV_IGNORE: ;
                default: state_nxt = DEV_IDLE;
            endcase
        end
    end

    always_comb begin
        src_sel_nxt = src_s;
        if (cfg0_r[SELECT_BIT]) begin
            fb_eff_nxt = fb_final(cfg1_r);
            ref_eff_nxt = ref_final(cfg0_r);
        end else begin
            fb_eff_nxt = mult_s ? PIN_MULT_HIGH : PIN_MULT_LOW;
            ref_eff_nxt = REF_BYPASS_DIV;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= DEV_IDLE;
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
            shift_r <= '0;
            rw_r <= RW_WRITE;
            mack_r <= 1'b0;
            sda_oe_r <= 1'b0;
            scl_d_r <= 1'b0;
            sda_d_r <= 1'b0;
            cfg0_r <= CFG_RESET;
            cfg1_r <= CFG_RESET;
            cfg2_r <= CFG_RESET;
            fb_eff_r <= PIN_MULT_LOW;
            ref_eff_r <= REF_BYPASS_DIV;
            src_sel_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            shift_r <= shift_nxt;
            rw_r <= rw_nxt;
            mack_r <= mack_nxt;
            sda_oe_r <= sda_oe_nxt;
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
            cfg0_r <= cfg0_nxt;
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
            fb_eff_r <= fb_eff_nxt;
            ref_eff_r <= ref_eff_nxt;
            src_sel_r <= src_sel_nxt;
        end
    end

    // Data line is open drain only; clock is never driven
    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_sda_oe = sda_oe_r;
    assign ref_divider_bypass = cfg0_r[BYPASS_BIT];
    assign use_programmed_dividers = cfg0_r[SELECT_BIT];
    assign ref_div_code = cfg0_r[REF_CODE_W-1:0];
    assign fb_div_code = cfg1_r;
    assign feedback_divider = fb_eff_r;
    assign reference_divider = ref_eff_r;
    assign bypass_clock_select = src_sel_r;
endmodule

/* hdl/twpdc_host.sv */
module twpdc_host #(
    parameter int QTR_CYCLES = twpdc_pkg::SCL_QTR_CYCLES
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic clk_en, // Freezes all state when low
    twpdc_if.host bus, // Serial link
    input wire logic xfer_start, // One-cycle request
    input wire logic xfer_read, // 1 read, 0 write
    input wire logic [7:0] wr_byte0, // First config byte
    input wire logic [7:0] wr_byte1, // Second config byte
    input wire logic [7:0] wr_byte2, // Third config byte
    output logic busy, // Transfer in progress
    output logic done, // One-cycle end pulse
    output logic nack_seen, // Device refused a byte
    output logic [23:0] rd_data // Read bytes, first in top
);
    import twpdc_pkg::*;

    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYCLES - 1);
    localparam logic [2:0] WR_LAST = DUMMY_BYTES + CFG_BYTES;
    localparam logic [2:0] RD_LAST = CFG_BYTES;

    function automatic logic [7:0] tx_pick(input logic [2:0] idx, input logic rd);
        logic [7:0] val;
        case (idx)
            3'h0: val = {DEV_ADDR, rd};
            3'h3: val = wr_byte0;
            3'h4: val = wr_byte1;
            3'h5: val = wr_byte2;
            default: val = DUMMY_VALUE;
        endcase
        return val;
    endfunction

    logic sda_s;

    twpdc_sync #(.WIDTH(1)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(bus.serial_data_pin),
        .sync_out(sda_s)
    );

    twpdc_host_state_type state_r, state_nxt;
    logic [QTR_W-1:0] qtr_r, qtr_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [2:0] byte_r, byte_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [23:0] rd_r, rd_nxt;
    logic rd_mode_r, rd_mode_nxt;
    logic scl_oe_r, scl_oe_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic nack_r, nack_nxt;
    logic tick;
    logic rx_byte;
    logic last_byte;

    always_comb begin
        state_nxt = state_r;
        qtr_nxt = qtr_r;
        phase_nxt = phase_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        rd_nxt = rd_r;
        rd_mode_nxt = rd_mode_r;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        nack_nxt = nack_r;
        tick = (qtr_r == QTR_LAST);
        rx_byte = rd_mode_r && byte_r != 3'h0;
        last_byte = byte_r == (rd_mode_r ? RD_LAST : WR_LAST);
        if (state_r != HST_IDLE) begin
            qtr_nxt = tick ? '0 : qtr_r + QTR_W'(1);
            if (tick) begin
                phase_nxt = phase_r + 2'h1;
            end
        end
        case (state_r)
            HST_IDLE: begin
                scl_oe_nxt = 1'b0;
                sda_oe_nxt = 1'b0;
                if (xfer_start) begin
                    state_nxt = HST_START;
                    qtr_nxt = '0;
                    phase_nxt = '0;
                    rd_mode_nxt = xfer_read;
                    busy_nxt = 1'b1;
                    nack_nxt = 1'b0;
                end
            end
            HST_START: begin
                if (tick) begin
                    case (phase_r)
                        2'h1: sda_oe_nxt = 1'b1; // Data falls, clock high
                        2'h2: scl_oe_nxt = 1'b1;
                        2'h3: begin
                            state_nxt = HST_BIT;
                            bit_nxt = '0;
                            byte_nxt = '0;
                            tx_nxt = tx_pick(3'h0, rd_mode_r);
                        end
                        default: ;
                    endcase
                end
            end
            HST_BIT: begin
                if (tick) begin
                    case (phase_r)
                        2'h0: begin
                            if (bit_r != BIT_CNT_FULL) begin
                                sda_oe_nxt = rx_byte ? 1'b0 : ~tx_r[7];
                            end else begin
                                sda_oe_nxt = rx_byte && !last_byte;
                            end
                        end
                        2'h1: scl_oe_nxt = 1'b0;
                        2'h2: begin
                            if (bit_r != BIT_CNT_FULL) begin
                                rx_nxt = {rx_r[6:0], sda_s};
                            end else if (!rx_byte && sda_s) begin
                                nack_nxt = 1'b1;
                            end
                        end
                        default: begin
                            scl_oe_nxt = 1'b1;
                            if (bit_r != BIT_CNT_FULL) begin
                                tx_nxt = {tx_r[6:0], 1'b0};
                                bit_nxt = bit_r + 4'h1;
                            end else begin
                                bit_nxt = '0;
                                if (rx_byte) begin
                                    rd_nxt = {rd_r[15:0], rx_r};
                                end
                                if (nack_r || last_byte) begin
                                    state_nxt = HST_STOP;
                                end else begin
                                    byte_nxt = byte_r + 3'h1;
                                    tx_nxt = tx_pick(byte_r + 3'h1, rd_mode_r);
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    case (phase_r)
                        2'h0: sda_oe_nxt = 1'b1;
                        2'h1: scl_oe_nxt = 1'b0;
                        2'h2: sda_oe_nxt = 1'b0; // Data rises, clock high
                        default: begin
                            state_nxt = HST_IDLE;
                            busy_nxt = 1'b0;
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= HST_IDLE;
            qtr_r <= '0;
            phase_r <= '0;
            bit_r <= '0;
            byte_r <= '0;
            tx_r <= '0;
            rx_r <= '0;
            rd_r <= '0;
            rd_mode_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            qtr_r <= qtr_nxt;
            phase_r <= phase_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            rd_r <= rd_nxt;
            rd_mode_r <= rd_mode_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            nack_r <= nack_nxt;
        end
    end

    assign bus.host_scl_out = 1'b0;
    assign bus.host_scl_oe = scl_oe_r;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe = sda_oe_r;
    assign busy = busy_r;
    assign done = done_r;
    assign nack_seen = nack_r;
    assign rd_data = rd_r;
endmodule

/* verification/twpdc_sva.sv */
module twpdc_sva (
    input wire logic core_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic host_scl_oe, // Host clock pull
    input wire logic host_sda_oe, // Host data pull
    input wire logic dev_sda_oe, // Device data pull
    input wire logic serial_clock_pin, // Resolved clock
    input wire logic serial_data_pin // Resolved data
);
    logic scl_q_r, sda_q_r, start_ev, stop_ev, rise_ev;
    logic [5:0] rise_cnt_r, rise_cnt_nxt, idle_cnt_r, idle_cnt_nxt;
    always_comb begin
        start_ev = scl_q_r & serial_clock_pin & sda_q_r & ~serial_data_pin;
        stop_ev = scl_q_r & serial_clock_pin & ~sda_q_r & serial_data_pin;
        rise_ev = ~scl_q_r & serial_clock_pin;
        rise_cnt_nxt = start_ev ? 6'h00 : rise_cnt_r + {5'h00, rise_ev};
        idle_cnt_nxt = serial_clock_pin ? idle_cnt_r + {5'h00, idle_cnt_r != 6'h3F} : 6'h00;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            rise_cnt_r <= 6'h00;
            idle_cnt_r <= 6'h00;
        end else begin
            scl_q_r <= serial_clock_pin;
            sda_q_r <= serial_data_pin;
            rise_cnt_r <= rise_cnt_nxt;
            idle_cnt_r <= idle_cnt_nxt;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_dev_chg; $changed(dev_sda_oe) |-> !serial_clock_pin; endproperty
    a_dev_chg: assert property (p_dev_chg) else $error("device data moved, clock high");
    property p_scl_hi; $rose(serial_clock_pin) |-> serial_clock_pin [*4]; endproperty
    a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
    property p_scl_lo; $fell(serial_clock_pin) |=> !serial_clock_pin [*3]; endproperty
    a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
    property p_ack; $rose(dev_sda_oe) |-> ##[1:64] $rose(serial_clock_pin) ##1 dev_sda_oe [*4];
    endproperty
    a_ack: assert property (p_ack) else $error("ack not held over clock high");
    property p_idle; idle_cnt_r > 6'h28 |-> !dev_sda_oe; endproperty
    a_idle: assert property (p_idle) else $error("device drives idle bus");
    property p_start; start_ev |-> $rose(host_sda_oe); endproperty
    a_start: assert property (p_start) else $error("start not made by host");
    property p_stop; stop_ev |-> $fell(host_sda_oe); endproperty
    a_stop: assert property (p_stop) else $error("stop not made by host");
    property p_frame; stop_ev |-> rise_cnt_r > 6'h01 && rise_cnt_r % 9 == 1; endproperty
    a_frame: assert property (p_frame) else $error("frame not whole bytes");
    c_write: cover property (stop_ev && rise_cnt_r == 6'h37);
    c_read: cover property (stop_ev && rise_cnt_r == 6'h25);
    c_ack: cover property ($rose(dev_sda_oe));
    c_pull: cover property ($rose(host_scl_oe));
endmodule

/* verification/twpdc_test.sv */
module twpdc_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, xfer_start = 1'b0, xfer_read = 1'b0;
    logic pll_mult_sel = 1'b0, clk_source_sel = 1'b0;
    logic [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00, fb_div_code;
    logic busy, done, nack_seen, ref_divider_bypass, use_programmed_dividers;
    logic bypass_clock_select;
    logic [5:0] ref_div_code;
    logic [9:0] feedback_divider;
    logic [6:0] reference_divider;
    logic [23:0] rd_data;
    int mismatches = 0, n_tests = 0;
    always #4 core_clk = ~core_clk;
    twpdc_if bus_if();
    twpdc_device i_twpdc_device (.core_clk, .rst, .clk_en, .bus(bus_if), .pll_mult_sel,
        .clk_source_sel, .ref_divider_bypass, .use_programmed_dividers, .ref_div_code,
        .fb_div_code, .feedback_divider, .reference_divider, .bypass_clock_select);
    twpdc_host #(.QTR_CYCLES(8)) i_twpdc_host (.core_clk, .rst, .clk_en, .bus(bus_if),
        .xfer_start, .xfer_read, .wr_byte0(b0), .wr_byte1(b1), .wr_byte2(b2), .busy, .done,
        .nack_seen, .rd_data);
    twpdc_sva i_twpdc_sva (.core_clk, .rst, .host_scl_oe(bus_if.host_scl_oe),
        .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe),
        .serial_clock_pin(bus_if.serial_clock_pin), .serial_data_pin(bus_if.serial_data_pin));
    function automatic logic [9:0] exp_fb();
        return b0[6] ? ({2'h0, b1} + 10'h003) << 1 : (pll_mult_sel ? 10'h008 : 10'h010);
    endfunction
    function automatic logic [6:0] exp_ref();
        return (b0[6] && !b0[7]) ? {1'b0, b0[5:0]} + 7'h02 : 7'h01;
    endfunction
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic rd);
        int i;
        @(negedge core_clk);
        xfer_start = 1'b1;
        xfer_read = rd;
        @(negedge core_clk);
        xfer_start = 1'b0;
        chk("busy", 24'h000001, {23'h0, busy});
        for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge core_clk);
        chk("done", 24'h000001, {23'h0, done});
        chk("busy_end", 24'h000000, {23'h0, busy});
        chk("nack", 24'h000000, {23'h0, nack_seen});
    endtask
    task automatic chk_all();
        repeat (4) @(negedge core_clk);
        chk("config", {b0, b1, 8'h00}, {ref_divider_bypass, use_programmed_dividers,
            ref_div_code, fb_div_code, 8'h00});
        chk("fb_div", {14'h0, exp_fb()}, {14'h0, feedback_divider});
        chk("ref_div", {17'h0, exp_ref()}, {17'h0, reference_divider});
        chk("src_sel", {23'h0, clk_source_sel}, {23'h0, bypass_clock_select});
    endtask
    initial begin
        int k;
        logic [9:0] hold_fb;
        logic hold_src;
        void'($urandom(74469));
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk_all();
        for (k = 0; k < 12; k++) begin
            // Clock enable low must freeze outputs while the pins move
            if (k == 6) begin
                hold_fb = exp_fb();
                hold_src = clk_source_sel;
                clk_en = 1'b0;
                pll_mult_sel = ~pll_mult_sel;
                clk_source_sel = ~clk_source_sel;
                repeat (8) @(negedge core_clk);
                chk("frozen_fb", {14'h0, hold_fb}, {14'h0, feedback_divider});
                chk("frozen_src", {23'h0, hold_src}, {23'h0, bypass_clock_select});
                clk_en = 1'b1;
            end
            pll_mult_sel = 1'($urandom);
            clk_source_sel = 1'($urandom);
            b0 = 8'($urandom);
            b1 = 8'($urandom);
            b2 = 8'($urandom);
            // Corners: every bypass and select pairing, extreme codes
            if (k < 4) b0[7:6] = 2'(k);
            if (k == 4) b0 = 8'h7F;
            if (k == 5) b1 = 8'hFF;
            xfer(1'b0);
            chk_all();
            xfer(1'b1);
            chk("read", {b0, b1, b2}, rd_data);
        end
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
